// File: hdl/ssim_top.sv
// Servo status outputs and digital input function map
`timescale 1ns/1ps
module ssim_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] judge_mode,
  input wire logic [31:0] position_deviation,
  input wire logic filtered_command_zero,
  input wire logic [15:0] position_complete_threshold,
  input wire logic [15:0] position_near_threshold,
  input wire logic [15:0] position_window_ms,
  input wire logic [15:0] position_hold_ms,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] speed_command,
  input wire logic [15:0] rotation_threshold,
  input wire logic [15:0] speed_consistent_threshold,
  input wire logic [15:0] speed_approach_threshold,
  input wire logic [15:0] zero_speed_threshold,
  input wire logic [15:0] actual_torque,
  input wire logic [15:0] torque_reached_threshold,
  input wire logic [15:0] torque_reached_hysteresis,
  input wire logic [13:0] fast_input_filter_time,
  input wire logic [7:0] input_pin,
  input wire logic [7:0] virtual_input,
  input wire logic [7:0] input_polarity,
  input wire logic [7:0] input_source,
  input wire logic [39:0] input_function,
  input wire logic input_function_load,
  output logic position_complete,
  output logic position_near,
  output logic motor_rotating,
  output logic speed_consistent,
  output logic speed_approaching,
  output logic zero_speed,
  output logic torque_reached,
  output logic servo_enable_fn,
  output logic fault_warning_reset_fn,
  output logic forward_limit_fn,
  output logic reverse_limit_fn,
  output logic zero_speed_hold_fn,
  output logic deviation_reset_fn,
  output logic command_negate_fn,
  output logic emergency_halt_fn,
  output logic gear_switch_fn,
  output logic gain_switch_fn,
  output logic position_reference_block_fn,
  output logic damping_switch_fn,
  output logic internal_speed_bit1,
  output logic internal_speed_bit2,
  output logic internal_speed_bit3,
  output logic inertia_switch_fn
);

  // Magnitude of a signed 16-bit value
  function automatic logic [15:0] mag16(input logic [15:0] v);
    mag16 = v[15] ? 16'((~v) + 16'h0001) : v;
  endfunction

  // Reset release through two flops
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Two-flop synchroniser for physical pins; only the second stage is read
  logic [7:0] pin_meta, pin_sync;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {pin_sync, pin_meta} <= 16'h0000;
    else
      {pin_sync, pin_meta} <= {pin_meta, input_pin};
  end

  // Fast pin filter: level must stay stable for the filter time
  logic [1:0] fast_state;
  logic [19:0] fast_cnt [2];
  logic [19:0] filter_cycles;
  logic [1:0] fast_raw;
  assign filter_cycles = 20'(fast_input_filter_time) * 20'(ssim_pkg::US_CYCLES);
  assign fast_raw = {pin_sync[ssim_pkg::FAST_B_IDX], pin_sync[ssim_pkg::FAST_A_IDX]};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_state <= 2'b00;
      fast_cnt <= '{20'h00000, 20'h00000};
    end
    else
      for (int f = 0; f < 2; f++)
        if (fast_raw[f] == fast_state[f])
          fast_cnt[f] <= 20'h00000;
        else if (fast_cnt[f] + 20'h00001 >= filter_cycles)
        begin
          fast_state[f] <= fast_raw[f];
          fast_cnt[f] <= 20'h00000;
        end
        else
          fast_cnt[f] <= fast_cnt[f] + 20'h00001;
  end

  // Physical level after filtering of the fast pair
  logic [7:0] pin_clean;
  assign pin_clean = {fast_state, pin_sync[5:0]};

  // Source and polarity per pin
  logic [7:0] pin_raw_sel;
  logic [7:0] pin_active;
  assign pin_raw_sel = (input_source & virtual_input) | (~input_source & pin_clean);
  assign pin_active = pin_raw_sel ^ input_polarity;

  // Function code table, defaults pin 1 enable, pin 2 fault reset
  logic [4:0] fn_code [8];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        fn_code[i] <= ssim_pkg::FN_NONE;
      fn_code[0] <= ssim_pkg::FN_SERVO_ENABLE;
      fn_code[1] <= ssim_pkg::FN_FAULT_RESET;
    end
    else if (input_function_load)
    begin
      for (int i = 0; i < 8; i++)
        fn_code[i] <= input_function[i*5 +: 5];
    end
  end

  // Map active pins to functions, any pin with a code from 1 to 16 drives it
  logic [16:0] fn_vec;
  always_comb
  begin
    fn_vec = 17'h00000;
    for (int i = 0; i < 8; i++)
      if (fn_code[i] != ssim_pkg::FN_NONE && fn_code[i] <= 5'h10)
        fn_vec[fn_code[i]] = fn_vec[fn_code[i]] | pin_active[i];
  end

  // Registered function outputs, bit n carries function code n
  logic [16:1] fn_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fn_q <= 16'h0000;
    else
      fn_q <= fn_vec[16:1];
  end
  assign {inertia_switch_fn, internal_speed_bit3, internal_speed_bit2, internal_speed_bit1,
          damping_switch_fn, position_reference_block_fn, gain_switch_fn, gear_switch_fn,
          emergency_halt_fn, command_negate_fn, deviation_reset_fn, zero_speed_hold_fn,
          reverse_limit_fn, forward_limit_fn, fault_warning_reset_fn, servo_enable_fn} = fn_q;

  // Speed and torque comparisons
  logic [15:0] speed_mag;
  logic [15:0] speed_err;
  logic [15:0] approach_thr;
  logic [15:0] hyst_eff;
  logic [16:0] torque_level;
  logic next_torque_reached;
  assign speed_mag = mag16(motor_speed);
  assign speed_err = mag16(16'(motor_speed - speed_command));
  assign approach_thr = (speed_approach_threshold < ssim_pkg::SPEED_APPROACH_THR_MIN) ?
                        ssim_pkg::SPEED_APPROACH_THR_MIN : speed_approach_threshold;
  assign hyst_eff = (torque_reached_hysteresis < ssim_pkg::TORQUE_HYST_MIN) ?
                    ssim_pkg::TORQUE_HYST_MIN :
                    (torque_reached_hysteresis > ssim_pkg::TORQUE_HYST_MAX) ?
                    ssim_pkg::TORQUE_HYST_MAX : torque_reached_hysteresis;
  assign torque_level = {1'b0, torque_reached_threshold} + {1'b0, hyst_eff};
  assign next_torque_reached = {1'b0, mag16(actual_torque)} >= torque_level;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      motor_rotating <= 1'b0;
      speed_consistent <= 1'b0;
      speed_approaching <= 1'b0;
      zero_speed <= 1'b0;
      torque_reached <= 1'b0;
    end
    else
    begin
      motor_rotating <= speed_mag > rotation_threshold;
      speed_consistent <= speed_err <= speed_consistent_threshold;
      speed_approaching <= speed_mag >= approach_thr;
      zero_speed <= speed_mag <= zero_speed_threshold;
      torque_reached <= next_torque_reached;
    end
  end

  // Deviation magnitude and positioning conditions
  logic [31:0] dev_mag;
  logic dev_complete;
  logic dev_near;
  logic pos_cond;
  logic [31:0] window_cycles;
  logic [31:0] hold_cycles;
  assign dev_mag = position_deviation[31] ? 32'((~position_deviation) + 32'h1) :
                   position_deviation;
  assign dev_complete = dev_mag < {16'h0000, position_complete_threshold};
  assign dev_near = dev_mag < {16'h0000, position_near_threshold};
  assign pos_cond = (judge_mode == ssim_pkg::JUDGE_WINDOW) ?
                    (dev_complete && filtered_command_zero) : dev_complete;
  assign window_cycles = 32'(position_window_ms) * 32'(ssim_pkg::MS_CYCLES);
  assign hold_cycles = 32'(position_hold_ms) * 32'(ssim_pkg::MS_CYCLES);

  // Positioning complete sequencer with window and hold
  ssim_pkg::ssim_pos_state_t pos_state;
  logic [31:0] pos_cnt;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_state <= ssim_pkg::SSIM_IDLE;
      pos_cnt <= 32'h0;
      position_complete <= 1'b0;
      position_near <= 1'b0;
    end
    else
    begin
      position_near <= dev_near;
      case (pos_state)
        ssim_pkg::SSIM_IDLE:
        begin
          pos_cnt <= 32'h0;
          position_complete <= 1'b0;
          if (pos_cond && judge_mode == ssim_pkg::JUDGE_WINDOW)
            pos_state <= ssim_pkg::SSIM_QUALIFY;
          else if (pos_cond)
          begin
            pos_state <= ssim_pkg::SSIM_HOLD;
            position_complete <= 1'b1;
          end
        end
        ssim_pkg::SSIM_QUALIFY:
        begin
          if (!pos_cond)
          begin
            pos_state <= ssim_pkg::SSIM_IDLE;
            pos_cnt <= 32'h0;
          end
          else if (pos_cnt + 32'h1 >= window_cycles)
          begin
            pos_state <= ssim_pkg::SSIM_HOLD;
            pos_cnt <= 32'h0;
            position_complete <= 1'b1;
          end
          else
            pos_cnt <= pos_cnt + 32'h1;
        end
        ssim_pkg::SSIM_HOLD:
        begin
          if (pos_cnt + 32'h1 >= hold_cycles && !pos_cond)
          begin
            pos_state <= ssim_pkg::SSIM_IDLE;
            position_complete <= 1'b0;
            pos_cnt <= 32'h0;
          end
          else if (pos_cnt + 32'h1 < hold_cycles)
            pos_cnt <= pos_cnt + 32'h1;
        end
        default:
        begin
          pos_state <= ssim_pkg::SSIM_IDLE;
          pos_cnt <= 32'h0;
          position_complete <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: hdl/ssim_pkg.sv
// Package for the servo status and input map block
package ssim_pkg;
  // Input pin count; pins 7 and 8 are the fast pair
  localparam int NUM_INPUTS = 8;
  localparam int FAST_A_IDX = 6;
  localparam int FAST_B_IDX = 7;
  // Clock rate and derived cycle counts
  localparam int CLK_HZ = 50000000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int US_CYCLES = CLK_HZ / 1000000;
  // Threshold reset values and clamp limits
  localparam logic [15:0] POS_COMPLETE_THR_RST = 16'h0320;
  localparam logic [15:0] POS_NEAR_THR_RST = 16'h1388;
  localparam logic [15:0] POS_WINDOW_MS_RST = 16'h000a;
  localparam logic [15:0] POS_HOLD_MS_RST = 16'h0064;
  localparam logic [15:0] ROTATION_THR_RST = 16'h0014;
  localparam logic [15:0] SPEED_CONSIST_THR_RST = 16'h000a;
  localparam logic [15:0] SPEED_APPROACH_THR_RST = 16'h0064;
  localparam logic [15:0] SPEED_APPROACH_THR_MIN = 16'h000a;
  localparam logic [15:0] ZERO_SPEED_THR_RST = 16'h000a;
  localparam logic [15:0] TORQUE_THR_RST = 16'h0064;
  localparam logic [15:0] TORQUE_HYST_RST = 16'h000a;
  localparam logic [15:0] TORQUE_HYST_MIN = 16'h000a;
  localparam logic [15:0] TORQUE_HYST_MAX = 16'h0014;
  localparam logic [13:0] FAST_FILTER_US_RST = 14'h0032;
  // Judging mode for the positioning complete output
  localparam logic [1:0] JUDGE_DEVIATION = 2'h0;
  localparam logic [1:0] JUDGE_WINDOW = 2'h3;
  // Function codes
  localparam logic [4:0] FN_NONE = 5'h00;
  localparam logic [4:0] FN_SERVO_ENABLE = 5'h01;
  localparam logic [4:0] FN_FAULT_RESET = 5'h02;
  localparam int NUM_FUNCTIONS = 17;
  // Positioning complete sequencer states
  typedef enum logic [1:0] {
    SSIM_IDLE = 2'b00,
    SSIM_QUALIFY = 2'b01,
    SSIM_HOLD = 2'b11
  } ssim_pos_state_t;
endpackage

// File: test/ssim_switches.sv
// Model of the contacts wired to the input pins
`timescale 1ns/1ps
module ssim_switches (
  input wire logic [7:0] closed,
  output logic [7:0] input_pin
);
  // A closed contact pulls its pin high
  assign input_pin = closed;
endmodule

// File: test/ssim_chk_sva.sv
// Checker for the status outputs of the servo status block
`timescale 1ns/1ps
module ssim_chk (
  input wire logic clk, reset_n, filtered_command_zero, position_complete, position_near,
  input wire logic motor_rotating, speed_approaching, zero_speed, torque_reached,
  input wire logic [1:0] judge_mode,
  input wire logic [31:0] position_deviation,
  input wire logic [15:0] position_complete_threshold, position_near_threshold,
  input wire logic [15:0] position_window_ms, position_hold_ms, motor_speed,
  input wire logic [15:0] rotation_threshold, speed_approach_threshold, zero_speed_threshold,
  input wire logic [15:0] actual_torque, torque_reached_threshold, torque_reached_hysteresis
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic [1:0] up;
  logic [31:0] hc, qc;
  // Magnitudes, clamped settings and compare results
  wire [31:0] da = position_deviation[31] ? -position_deviation : position_deviation;
  wire [15:0] sa = motor_speed[15] ? -motor_speed : motor_speed;
  wire [15:0] ta = actual_torque[15] ? -actual_torque : actual_torque;
  wire [15:0] h0 = torque_reached_hysteresis < 16'h000a ? 16'h000a : torque_reached_hysteresis;
  wire [16:0] tl = torque_reached_threshold + (h0 > 16'h0014 ? 16'h0014 : h0);
  wire [15:0] ap = speed_approach_threshold < 16'h000a ? 16'h000a : speed_approach_threshold;
  wire live = up == 2'h3;
  wire m3 = judge_mode == 2'h3;
  wire pc = da < 32'(position_complete_threshold);
  wire nr = da < 32'(position_near_threshold);
  wire tq = 17'(ta) >= tl;
  wire [31:0] wc = position_window_ms * ssim_pkg::MS_CYCLES;
  wire [31:0] hd = position_hold_ms * ssim_pkg::MS_CYCLES;
  // Edges since release, run lengths of qualify and of high output
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      up <= 2'h0;
      hc <= 32'h0;
      qc <= 32'h0;
    end
    else
    begin
      up <= live ? up : up + 2'h1;
      hc <= position_complete ? hc + 32'h1 : 32'h0;
      qc <= pc && filtered_command_zero ? qc + 32'h1 : 32'h0;
    end
  end
  trq_level_a: assert property (live |-> torque_reached == $past(tq))
    else $error("torque flag wrong");
  rot_speed_a: assert property (live |-> motor_rotating == $past(sa > rotation_threshold))
    else $error("rotating flag wrong");
  appr_speed_a: assert property (live |-> speed_approaching == $past(sa >= ap))
    else $error("approach flag wrong");
  zero_speed_a: assert property (live |-> zero_speed == $past(sa <= zero_speed_threshold))
    else $error("zero speed flag wrong");
  near_pos_a: assert property (live && !$past(m3) |-> position_near == $past(nr))
    else $error("near flag wrong");
  cmp_mode0_a: assert property (live && !m3 && pc |=> position_complete)
    else $error("complete late in mode 0");
  hold_time_a: assert property ($fell(position_complete) |-> hc >= hd)
    else $error("complete hold too short");
  win_time_a: assert property ($rose(position_complete) && m3 |-> qc >= wc)
    else $error("complete before window");
  cover property (live && torque_reached);
  cover property ($rose(position_complete) && m3);
  cover property ($fell(position_complete) && hd != 32'h0);
endmodule
bind ssim_top ssim_chk ssim_chk_inst (.*);

// File: test/tb_servo_status_and_input_map.sv
// Testbench for the servo status and input map block
`timescale 1ns/1ps
module tb_servo_status_and_input_map;
  logic clk = 1'b0, reset_n = 1'b0, filtered_command_zero = 1'b0, input_function_load = 1'b0;
  logic [1:0] judge_mode = 2'h0;
  logic [31:0] position_deviation = 32'h0000ffff;
  logic [15:0] position_complete_threshold = 16'h0320, position_near_threshold = 16'h1388;
  logic [15:0] position_window_ms = 16'h0001, position_hold_ms = 16'h0000;
  logic [15:0] motor_speed = 16'h0000, speed_command = 16'h0032, rotation_threshold = 16'h0014;
  logic [15:0] speed_consistent_threshold = 16'h000a, speed_approach_threshold = 16'h0005;
  logic [15:0] zero_speed_threshold = 16'h000a, actual_torque = 16'h0000;
  logic [15:0] torque_reached_threshold = 16'h0064, torque_reached_hysteresis = 16'h000a;
  logic [13:0] fast_input_filter_time = 14'h0001;
  logic [7:0] closed = 8'h00, virtual_input = 8'h00, input_polarity = 8'h00, input_source = 8'h00;
  logic [39:0] input_function = 40'h0;
  wire [7:0] input_pin;
  wire [16:1] fn;
  wire position_complete, position_near, motor_rotating, speed_consistent;
  wire speed_approaching, zero_speed, torque_reached;
  wire [3:0] sf = {motor_rotating, speed_consistent, speed_approaching, zero_speed};
  int mismatches = 0, total_checks = 0, n;
  // Tables: value then expected flags
  logic [19:0] st [5] = '{20'h0015a, 20'h00142, 20'h00091, 20'hffd8a, 20'h003ce};
  logic [27:0] tt [6] = '{28'h0a006e1, 28'h0a006d0, 28'h0aff921, 28'h05006d0, 28'h1e00770,
    28'h1e00781};
  logic [35:0] pt [5] = '{36'h0000031f3, 36'h000003201, 36'hfffffce13, 36'h000013871,
    36'h000013880};
  // 50 MHz clock
  always #10 clk = ~clk;
  // Contacts on the pins and the block under test
  ssim_switches ssim_switches_inst (.closed, .input_pin);
  ssim_top ssim_top_inst (
    .*,
    .servo_enable_fn(fn[1]), .fault_warning_reset_fn(fn[2]), .forward_limit_fn(fn[3]),
    .reverse_limit_fn(fn[4]), .zero_speed_hold_fn(fn[5]), .deviation_reset_fn(fn[6]),
    .command_negate_fn(fn[7]), .emergency_halt_fn(fn[8]), .gear_switch_fn(fn[9]),
    .gain_switch_fn(fn[10]), .position_reference_block_fn(fn[11]),
    .damping_switch_fn(fn[12]), .internal_speed_bit1(fn[13]),
    .internal_speed_bit2(fn[14]), .internal_speed_bit3(fn[15]), .inertia_switch_fn(fn[16])
  );
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input string s, input logic [35:0] e, input logic [35:0] a);
    total_checks++;
    if (a !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, a);
    end
  endtask
  // Bounded wait on complete or on the gear function
  task automatic wt(input logic w, input bit p, input int lim);
    n = 0;
    while ((p ? position_complete : fn[9]) !== w && n < lim)
    begin
      cyc(1);
      n++;
    end
    if (n >= lim)
    begin
      mismatches++;
      $display("[ERR] wait expected %h seen timeout", w);
      complete_run();
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset;
    cyc(2);
    chk("zero_speed", 36'h0, zero_speed);
    cyc(1);
    chk("zero_speed", 36'h1, zero_speed);
    closed = 8'h03;
    cyc(2);
    chk("fn", 36'h0, fn);
    cyc(1);
    chk("fn", 36'h3, fn);
    closed = 8'h00;
    cyc(3);
    $display("t_reset done");
  endtask
  task automatic t_map;
    input_source[2] = 1'b1;
    for (int c = 17; c > 0; c--)
    begin
      input_function[14:10] = 5'(c);
      input_function_load = 1'b1;
      cyc(1);
      input_function_load = 1'b0;
      virtual_input[2] = 1'b1;
      cyc(1);
      chk("fn", c < 17 ? 36'h1 << (c - 1) : 36'h0, fn);
      virtual_input[2] = 1'b0;
      cyc(1);
    end
    input_polarity[2] = 1'b1;
    cyc(1);
    chk("fn open", 36'h1, fn);
    input_polarity[2] = 1'b0;
    input_source[2] = 1'b0;
    cyc(1);
    $display("t_map done");
  endtask
  task automatic t_fast;
    input_function[34:30] = 5'h09;
    input_function_load = 1'b1;
    cyc(1);
    input_function_load = 1'b0;
    closed[6] = 1'b1;
    cyc(30);
    closed[6] = 1'b0;
    cyc(80);
    chk("gear glitch", 36'h0, fn[9]);
    closed[6] = 1'b1;
    wt(1'b1, 1'b0, 100);
    chk("gear lag", 36'h1, n >= 50 && n <= 56);
    $display("t_fast done");
  endtask
  task automatic t_speed;
    for (int i = 0; i < 5; i++)
    begin
      motor_speed = st[i][19:4];
      cyc(1);
      chk("speed flags", st[i][3:0], sf);
    end
    $display("t_speed done");
  endtask
  task automatic t_torque;
    for (int i = 0; i < 6; i++)
    begin
      torque_reached_hysteresis = {8'h00, tt[i][27:20]};
      actual_torque = tt[i][19:4];
      cyc(1);
      chk("torque", tt[i][3:0], torque_reached);
    end
    $display("t_torque done");
  endtask
  task automatic t_pos0;
    for (int i = 0; i < 5; i++)
    begin
      position_deviation = pt[i][35:4];
      cyc(1);
      chk("pos flags", pt[i][3:0], {position_complete, position_near});
    end
    $display("t_pos0 done");
  endtask
  task automatic t_pos3;
    judge_mode = 2'h3;
    position_hold_ms = 16'h0001;
    position_deviation = 32'h0;
    cyc(100);
    chk("cmd not zero", 36'h0, position_complete);
    filtered_command_zero = 1'b1;
    wt(1'b1, 1'b1, 50100);
    chk("window", 36'h1, n >= 50000 && n <= 50003);
    filtered_command_zero = 1'b0;
    wt(1'b0, 1'b1, 50100);
    chk("hold", 36'h1, n >= 49998 && n <= 50002);
    $display("t_pos3 done");
  endtask
  initial
  begin
    cyc(6);
    reset_n = 1'b1;
    t_reset();
    t_map();
    t_fast();
    t_speed();
    t_torque();
    t_pos0();
    t_pos3();
    complete_run();
  end
endmodule
